// ==== verilog/twm_pkg.sv ====
// Purpose: Shared constants and types of the two-wire master task/event block
// Assumes: 32-bit APB, 12-bit byte address window
// Notes:   Offsets are byte addresses
package twm_pkg;

    // ------------------------------------------------------------------
    // Bus shape
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_START_RECEIVE_TASK  = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_START_TRANSMIT_TASK = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_STOP_TASK           = 12'h014;
    localparam logic [ADDR_W-1:0] OFF_SUSPEND_TASK        = 12'h01C;
    localparam logic [ADDR_W-1:0] OFF_RESUME_TASK         = 12'h020;
    localparam logic [ADDR_W-1:0] OFF_STOPPED_EVENT       = 12'h104;
    localparam logic [ADDR_W-1:0] OFF_ERROR_EVENT         = 12'h124;
    localparam logic [ADDR_W-1:0] OFF_SUSPENDED_EVENT     = 12'h148;
    localparam logic [ADDR_W-1:0] OFF_RECEIVE_STARTED_EVT = 12'h14C;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS          = 12'h310;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK            = 12'h314;
    localparam logic [ADDR_W-1:0] OFF_TX_DATA             = 12'h580;
    localparam logic [ADDR_W-1:0] OFF_RX_DATA             = 12'h584;
    localparam logic [ADDR_W-1:0] OFF_SLAVE_ADDR          = 12'h588;

    // Event index order matches the event struct bits
    localparam int NUM_EVT = 4;
    localparam logic [ADDR_W-1:0] EVT_OFF [NUM_EVT] = '{
        OFF_STOPPED_EVENT, OFF_ERROR_EVENT, OFF_SUSPENDED_EVENT, OFF_RECEIVE_STARTED_EVT};

    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int TRIG_BIT  = 0;
    localparam int BYTE_W    = 8;
    localparam int SADDR_W   = 7;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Timing: quarter of one bus bit
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int QTR_TIME_NS   = 2500;
    localparam int QTR_CYCLES    = (QTR_TIME_NS * 1000) / CLK_PERIOD_PS;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_BIT   = 3'b010,
        ST_SUSP  = 3'b011,
        ST_STOP  = 3'b100
    } twm_state_e;

    typedef struct packed {
        logic receive_started;
        logic suspended;
        logic error;
        logic stopped;
    } twm_evt_s;

    typedef struct packed {
        twm_state_e st;
        logic [1:0] ph;
        logic [3:0] bitn;
        logic [7:0] shift;
        logic       rw;
        logic       first;
        logic       susp_req;
        logic       stop_req;
        logic       scl_oe;
        logic       sda_oe;
        logic [7:0] rxdata;
    } twm_eng_s;

endpackage

// ==== verilog/twm_regs.sv ====
// Purpose: Two-wire bus master with APB task and event registers
// Assumes: pclk 200 MHz, presetn async active low, ce freezes all state
// Notes:   Bus pins are open drain; oe high pulls the wire low
`timescale 1ns/1ps

module twm_regs #(
    parameter int QTR_CYCLES = twm_pkg::QTR_CYCLES
) (
    // Clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        ce,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [twm_pkg::ADDR_W-1:0] paddr,
    input  wire logic [twm_pkg::DATA_W-1:0] pwdata,
    output logic      [twm_pkg::DATA_W-1:0] prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Interrupt
    output logic                             irq,
    // Two-wire bus pins
    input  wire logic                        scl_in,
    output logic                             scl_oe,
    input  wire logic                        sda_in,
    output logic                             sda_oe
);

    localparam int CW = $clog2(QTR_CYCLES + 1);
    localparam logic [CW-1:0] RELOAD = CW'(QTR_CYCLES - 1);

    if (QTR_CYCLES < 1) begin : g_chk
        $error("QTR_CYCLES must be at least one");
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic scl_s1_r, scl_s2_r, sda_s1_r, sda_s2_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
        end else if (ce) begin
            scl_s1_r <= scl_in;
            scl_s2_r <= scl_s1_r;
            sda_s1_r <= sda_in;
            sda_s2_r <= sda_s1_r;
        end
    end

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    logic                       pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic [twm_pkg::DATA_W-1:0] prdata_r, prdata_nxt;
    logic                       acc, wr_done, trig;
    logic                       task_rx, task_tx, task_stop, task_susp, task_res;
    twm_pkg::twm_evt_s          evt_r, evt_nxt, set_v, ist_r, ist_nxt, imask_r, imask_nxt;
    logic [twm_pkg::NUM_EVT-1:0] evt_wr;
    logic [7:0]                 txdata_r, txdata_nxt;
    logic [6:0]                 saddr_r, saddr_nxt;
    logic                       irq_r, irq_nxt, hit;
    twm_pkg::twm_eng_s          eng_r, eng_nxt;
    logic [CW-1:0]              cnt_r, cnt_nxt;

    assign acc     = psel && penable && !pready_r;
    assign wr_done = psel && penable && pready_r && pwrite;
    assign trig    = wr_done && pwdata[twm_pkg::TRIG_BIT];
    assign task_rx   = trig && (paddr == twm_pkg::OFF_START_RECEIVE_TASK);
    assign task_tx   = trig && (paddr == twm_pkg::OFF_START_TRANSMIT_TASK);
    assign task_stop = trig && (paddr == twm_pkg::OFF_STOP_TASK);
    assign task_susp = trig && (paddr == twm_pkg::OFF_SUSPEND_TASK);
    assign task_res  = trig && (paddr == twm_pkg::OFF_RESUME_TASK);

    always_comb begin
        prdata_nxt = prdata_r;
        hit        = 1'b1;
        if (acc) begin
            prdata_nxt = twm_pkg::RST_WORD;
            case (paddr)
                twm_pkg::OFF_START_RECEIVE_TASK, twm_pkg::OFF_START_TRANSMIT_TASK,
                twm_pkg::OFF_STOP_TASK, twm_pkg::OFF_SUSPEND_TASK,
                twm_pkg::OFF_RESUME_TASK: prdata_nxt = twm_pkg::RST_WORD;
                twm_pkg::OFF_STOPPED_EVENT:       prdata_nxt[0] = evt_r.stopped;
                twm_pkg::OFF_ERROR_EVENT:         prdata_nxt[0] = evt_r.error;
                twm_pkg::OFF_SUSPENDED_EVENT:     prdata_nxt[0] = evt_r.suspended;
                twm_pkg::OFF_RECEIVE_STARTED_EVT: prdata_nxt[0] = evt_r.receive_started;
                twm_pkg::OFF_IRQ_STATUS: prdata_nxt[twm_pkg::NUM_EVT-1:0] = ist_r;
                twm_pkg::OFF_IRQ_MASK:   prdata_nxt[twm_pkg::NUM_EVT-1:0] = imask_r;
                twm_pkg::OFF_TX_DATA:    prdata_nxt[twm_pkg::BYTE_W-1:0] = txdata_r;
                twm_pkg::OFF_RX_DATA:    prdata_nxt[twm_pkg::BYTE_W-1:0] = eng_r.rxdata;
                twm_pkg::OFF_SLAVE_ADDR: prdata_nxt[twm_pkg::SADDR_W-1:0] = saddr_r;
                default:                 hit = 1'b0;
            endcase
        end
        pready_nxt  = acc;
        pslverr_nxt = acc && !hit;
    end

    // ------------------------------------------------------------------
    // Event, interrupt and data registers
    // ------------------------------------------------------------------
    for (genvar i = 0; i < twm_pkg::NUM_EVT; i++) begin : g_evt
        assign evt_wr[i] = wr_done && (paddr == twm_pkg::EVT_OFF[i]);
        // Hardware set wins over a software write of zero
        assign evt_nxt[i] = set_v[i] |
                            (evt_wr[i] ? pwdata[twm_pkg::TRIG_BIT] : evt_r[i]);
    end

    always_comb begin
        ist_nxt   = ist_r;
        imask_nxt = imask_r;
        txdata_nxt = txdata_r;
        saddr_nxt  = saddr_r;
        if (wr_done && paddr == twm_pkg::OFF_IRQ_STATUS)
            ist_nxt = ist_r & ~pwdata[twm_pkg::NUM_EVT-1:0];
        if (wr_done && paddr == twm_pkg::OFF_IRQ_MASK)
            imask_nxt = pwdata[twm_pkg::NUM_EVT-1:0];
        if (wr_done && paddr == twm_pkg::OFF_TX_DATA)
            txdata_nxt = pwdata[twm_pkg::BYTE_W-1:0];
        if (wr_done && paddr == twm_pkg::OFF_SLAVE_ADDR)
            saddr_nxt = pwdata[twm_pkg::SADDR_W-1:0];
        ist_nxt = ist_nxt | set_v;
        irq_nxt = |(ist_nxt & imask_nxt);
    end

    // ------------------------------------------------------------------
    // Bus engine
    // ------------------------------------------------------------------
    logic tick, drive_low, busy;

    assign tick = (cnt_r == '0);
    assign busy = (eng_r.st == twm_pkg::ST_START) || (eng_r.st == twm_pkg::ST_BIT);

    always_comb begin
        eng_nxt = eng_r;
        set_v   = '0;
        cnt_nxt = tick ? cnt_r : cnt_r - CW'(1);
        if (eng_r.bitn == twm_pkg::ACK_BIT)
            drive_low = !eng_r.first && eng_r.rw;
        else
            drive_low = (eng_r.first || !eng_r.rw) && !eng_r.shift[7];
        if (task_susp && busy)
            eng_nxt.susp_req = 1'b1;
        if (task_stop && busy)
            eng_nxt.stop_req = 1'b1;
        case (eng_r.st)
            twm_pkg::ST_IDLE: begin
                if (task_rx || task_tx) begin
                    eng_nxt.st       = twm_pkg::ST_START;
                    eng_nxt.ph       = 2'h0;
                    eng_nxt.rw       = task_rx;
                    eng_nxt.first    = 1'b1;
                    eng_nxt.shift    = {saddr_r, task_rx};
                    eng_nxt.susp_req = 1'b0;
                    eng_nxt.stop_req = 1'b0;
                    set_v.receive_started = task_rx;
                    cnt_nxt = RELOAD;
                end else if (task_stop) begin
                    set_v.stopped = 1'b1;
                end
            end
            twm_pkg::ST_START: begin
                if (tick) begin
                    cnt_nxt = RELOAD;
                    if (eng_r.ph == 2'h0) begin
                        eng_nxt.sda_oe = 1'b1;
                        eng_nxt.ph     = 2'h1;
                    end else begin
                        eng_nxt.scl_oe = 1'b1;
                        eng_nxt.st     = twm_pkg::ST_BIT;
                        eng_nxt.ph     = 2'h0;
                        eng_nxt.bitn   = 4'h0;
                    end
                end
            end
            twm_pkg::ST_BIT: begin
                if (tick) begin
                    cnt_nxt = RELOAD;
                    case (eng_r.ph)
                        2'h0: begin
                            eng_nxt.sda_oe = drive_low;
                            eng_nxt.ph     = 2'h1;
                        end
                        2'h1: begin
                            eng_nxt.scl_oe = 1'b0;
                            eng_nxt.ph     = 2'h2;
                        end
                        2'h2: begin
                            if (scl_s2_r)
                                eng_nxt.ph = 2'h3;
                        end
                        default: begin
                            eng_nxt.scl_oe = 1'b1;
                            eng_nxt.ph     = 2'h0;
                            if (eng_r.bitn != twm_pkg::ACK_BIT) begin
                                eng_nxt.shift = {eng_r.shift[6:0], sda_s2_r};
                                eng_nxt.bitn  = eng_r.bitn + 4'h1;
                            end else begin
                                // Nack is flagged only; traffic goes on
                                set_v.error = (eng_r.first || !eng_r.rw) && sda_s2_r;
                                if (!eng_r.first && eng_r.rw)
                                    eng_nxt.rxdata = eng_r.shift;
                                eng_nxt.first = 1'b0;
                                eng_nxt.bitn  = 4'h0;
                                eng_nxt.shift = eng_r.rw ? 8'hFF : txdata_r;
                                if (eng_nxt.stop_req) begin
                                    eng_nxt.st = twm_pkg::ST_STOP;
                                end else if (eng_nxt.susp_req) begin
                                    eng_nxt.st       = twm_pkg::ST_SUSP;
                                    eng_nxt.susp_req = 1'b0;
                                    set_v.suspended  = 1'b1;
                                end
                            end
                        end
                    endcase
                end
            end
            twm_pkg::ST_SUSP: begin
                if (task_res) begin
                    eng_nxt.st = twm_pkg::ST_BIT;
                    eng_nxt.ph = 2'h0;
                    cnt_nxt    = RELOAD;
                end
            end
            twm_pkg::ST_STOP: begin
                if (tick) begin
                    cnt_nxt = RELOAD;
                    case (eng_r.ph)
                        2'h0: begin
                            eng_nxt.sda_oe = 1'b1;
                            eng_nxt.ph     = 2'h1;
                        end
                        2'h1: begin
                            eng_nxt.scl_oe = 1'b0;
                            eng_nxt.ph     = 2'h2;
                        end
                        2'h2: begin
                            if (scl_s2_r) begin
                                eng_nxt.sda_oe = 1'b0;
                                eng_nxt.ph     = 2'h3;
                            end
                        end
                        default: begin
                            eng_nxt.st       = twm_pkg::ST_IDLE;
                            eng_nxt.ph       = 2'h0;
                            eng_nxt.stop_req = 1'b0;
                            set_v.stopped    = 1'b1;
                        end
                    endcase
                end
            end
            default: begin
                eng_nxt = '0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
            evt_r     <= '0;
            ist_r     <= '0;
            imask_r   <= '0;
            txdata_r  <= '0;
            saddr_r   <= '0;
            irq_r     <= 1'b0;
            eng_r     <= '0;
            cnt_r     <= '0;
        end else if (ce) begin
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
            evt_r     <= evt_nxt;
            ist_r     <= ist_nxt;
            imask_r   <= imask_nxt;
            txdata_r  <= txdata_nxt;
            saddr_r   <= saddr_nxt;
            irq_r     <= irq_nxt;
            eng_r     <= eng_nxt;
            cnt_r     <= cnt_nxt;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign irq     = irq_r;
    assign scl_oe  = eng_r.scl_oe;
    assign sda_oe  = eng_r.sda_oe;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_start_rx;
        ce && task_rx && eng_r.st == twm_pkg::ST_IDLE
            |=> eng_r.st == twm_pkg::ST_START && eng_r.rw && evt_r.receive_started;
    endproperty
    a_start_rx: assert property (p_start_rx) else $error("receive start not taken");

    property p_start_tx;
        ce && task_tx && eng_r.st == twm_pkg::ST_IDLE
            |=> eng_r.st == twm_pkg::ST_START && !eng_r.rw && eng_r.first;
    endproperty
    a_start_tx: assert property (p_start_tx) else $error("transmit start not taken");

    property p_stop_end;
        ce && eng_r.st == twm_pkg::ST_STOP && eng_nxt.st == twm_pkg::ST_IDLE
            |=> evt_r.stopped && !scl_oe && !sda_oe;
    endproperty
    a_stop_end: assert property (p_stop_end) else $error("stop did not end cleanly");

    property p_susp;
        ce && eng_r.st == twm_pkg::ST_BIT && eng_nxt.st == twm_pkg::ST_SUSP
            |-> eng_r.bitn == twm_pkg::ACK_BIT && eng_r.ph == 2'h3 ##1 evt_r.suspended;
    endproperty
    a_susp: assert property (p_susp) else $error("suspend not at byte end");

    property p_susp_hold;
        eng_r.st == twm_pkg::ST_SUSP && !task_res |=> $stable(scl_oe) && scl_oe;
    endproperty
    a_susp_hold: assert property (p_susp_hold) else $error("traffic moved while held");

    property p_no_auto_stop;
        eng_nxt.st == twm_pkg::ST_STOP |-> eng_r.stop_req || task_stop;
    endproperty
    a_no_auto_stop: assert property (p_no_auto_stop) else $error("stopped by itself");

    property p_evt_sticky;
        ce && evt_r.error && !(evt_wr[1] && !pwdata[twm_pkg::TRIG_BIT]) |=> evt_r.error;
    endproperty
    a_evt_sticky: assert property (p_evt_sticky) else $error("event lost");

    property p_apb_answer;
        psel && penable && !pready_r && ce |=> pready_r;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("apb answer late");

    c_rx:   cover property (task_rx ##[1:1000] eng_r.st == twm_pkg::ST_BIT);
    c_susp: cover property (eng_r.st == twm_pkg::ST_SUSP ##[1:1000] task_res);
    c_stop: cover property (eng_r.st == twm_pkg::ST_STOP ##[1:1000] evt_r.stopped);

endmodule

// ==== dv/twm_slave_model.sv ====
// Purpose: Behavioural two-wire slave for the bench
// Assumes: Open-drain wires resolved by the bench
// Notes:   Acks address and written bytes while ack_en is high
`timescale 1ns/1ps
module twm_slave_model (
    // Wire levels
    input  wire logic       scl,
    input  wire logic       sda,
    // Behaviour controls
    input  wire logic       ack_en,
    input  wire logic       slow,
    input  wire logic [7:0] rd_byte,
    // Pin drive
    output logic            sda_oe,
    output logic            scl_oe
);
    int         n   = -1;
    logic       adr = 1'b1;
    logic       rd  = 1'b0;
    logic [7:0] sh  = 8'h00;
    initial begin
        sda_oe = 1'b0;
        scl_oe = 1'b0;
    end
    // Start condition
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            n = -1;
            adr = 1'b1;
        end
    end
    always @(posedge scl) begin
        if (n >= 0 && n < 8) begin
            sh = {sh[6:0], sda};
        end
    end
    // Ack slot, read data, optional clock stretch
    always @(negedge scl) begin
        n = n + 1;
        if (n == 9) begin
            n = 0;
            if (adr) begin
                rd = sh[0];
            end
            adr = 1'b0;
        end
        if (n == 8) begin
            sda_oe = ack_en && (adr || !rd);
        end else begin
            sda_oe = !adr && rd && !rd_byte[7-n];
        end
        if (slow) begin
            scl_oe = 1'b1;
            #60;
            scl_oe = 1'b0;
        end
    end
endmodule

// ==== dv/two_wire_master_task_event_regs_bench.sv ====
// Purpose: Self-checking bench of the task and event registers
// Assumes: QTR_CYCLES of 2, slave model on the wires
// Notes:   APB tasks hold each request until pready
`timescale 1ns/1ps
module two_wire_master_task_event_regs_bench;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        pclk, presetn, ce, psel, penable, pwrite, irq, ack_en, slow;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, scl_oe, sda_oe, s_sda_oe, s_scl_oe, scl_w, sda_w;
    logic [8:0]  cap;
    int          nbits = 0;
    int          num_errors = 0;
    int          check_count = 0;
    int          k0;
    assign scl_w = ~(scl_oe | s_scl_oe);
    assign sda_w = ~(sda_oe | s_sda_oe);
    twm_regs #(.QTR_CYCLES(2)) twm_regs_i (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .scl_in(scl_w),
        .scl_oe(scl_oe), .sda_in(sda_w), .sda_oe(sda_oe));
    twm_slave_model twm_slave_model_i (
        .scl(scl_w), .sda(sda_w), .ack_en(ack_en), .slow(slow),
        .rd_byte(8'hA5), .sda_oe(s_sda_oe), .scl_oe(s_scl_oe));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // Bit monitor on the wires
    always @(negedge sda_w) begin
        if (scl_w === 1'b1) nbits = 0;
    end
    always @(posedge scl_w) begin
        if (nbits < 9) cap = {cap[7:0], sda_w};
        nbits = nbits + 1;
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic tally_and_finish;
        if (num_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            num_errors++;
            tally_and_finish();
        end else begin
            @(posedge pclk);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk(q, x);
    endtask
    task automatic wait_evt(input logic [11:0] a);
        logic [31:0] q;
        logic        e;
        int          k;
        q = '0;
        for (k = 0; k < 300 && q[0] !== 1'b1; k++) apb(1'b0, a, 32'h0000_0000, q, e);
        chk(q, 32'h0000_0001);
        if (q[0] !== 1'b1) tally_and_finish();
    endtask
    task automatic wait_bits(input int n);
        int k;
        for (k = 0; k < 3000 && nbits < n; k++) @(posedge pclk);
        if (nbits < n) begin
            num_errors++;
            tally_and_finish();
        end
    endtask
    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] q;
        logic        e;
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        ack_en = 1'b1;
        slow = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < twm_pkg::NUM_EVT; i++) rd(twm_pkg::EVT_OFF[i], 32'h0000_0000);
        rd(twm_pkg::OFF_START_TRANSMIT_TASK, 32'h0000_0000);
        rd(twm_pkg::OFF_STOP_TASK, 32'h0000_0000);
        apb(1'b0, 12'h0FC, 32'h0000_0000, q, e);
        chk({31'b0, e}, 32'h0000_0001);
        // Stop in idle, masked and unmasked
        wr(twm_pkg::OFF_IRQ_MASK, 32'h0000_0001);
        wr(twm_pkg::OFF_STOP_TASK, 32'h0000_0001);
        rd(twm_pkg::OFF_STOPPED_EVENT, 32'h0000_0001);
        rd(twm_pkg::OFF_STOPPED_EVENT, 32'h0000_0001);
        chk({31'b0, irq}, 32'h0000_0001);
        wr(twm_pkg::OFF_STOPPED_EVENT, 32'h0000_0000);
        rd(twm_pkg::OFF_STOPPED_EVENT, 32'h0000_0000);
        wr(twm_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
        wr(twm_pkg::OFF_IRQ_MASK, 32'h0000_0000);
        wr(twm_pkg::OFF_STOP_TASK, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        #1 chk({31'b0, irq}, 32'h0000_0000);
        wr(twm_pkg::OFF_STOPPED_EVENT, 32'h0000_0000);
        // Transmit, suspend, resume, stop
        wr(twm_pkg::OFF_SLAVE_ADDR, 32'h0000_002A);
        wr(twm_pkg::OFF_TX_DATA, 32'h0000_005A);
        wr(twm_pkg::OFF_START_TRANSMIT_TASK, 32'h0000_0000);
        repeat (20) @(posedge pclk);
        #1 chk({31'b0, sda_oe}, 32'h0000_0000);
        wr(twm_pkg::OFF_START_TRANSMIT_TASK, 32'h0000_0001);
        wait_bits(10);
        chk({23'b0, cap}, {23'b0, 7'h2A, 1'b0, 1'b0});
        wr(twm_pkg::OFF_SUSPEND_TASK, 32'h0000_0001);
        wait_evt(twm_pkg::OFF_SUSPENDED_EVENT);
        chk(nbits % 9, 32'h0000_0000);
        k0 = nbits;
        repeat (60) @(posedge pclk);
        #1 chk(nbits, k0);
        chk({31'b0, scl_oe}, 32'h0000_0001);
        wr(twm_pkg::OFF_RESUME_TASK, 32'h0000_0001);
        wait_bits(k0 + 3);
        wr(twm_pkg::OFF_STOP_TASK, 32'h0000_0001);
        wait_evt(twm_pkg::OFF_STOPPED_EVENT);
        repeat (10) @(posedge pclk);
        #1 chk({30'b0, scl_w, sda_w}, 32'h0000_0003);
        // Nack keeps traffic going
        wr(twm_pkg::OFF_STOPPED_EVENT, 32'h0000_0000);
        ack_en <= 1'b0;
        wr(twm_pkg::OFF_START_TRANSMIT_TASK, 32'h0000_0001);
        wait_evt(twm_pkg::OFF_ERROR_EVENT);
        wait_bits(27);
        rd(twm_pkg::OFF_STOPPED_EVENT, 32'h0000_0000);
        ack_en <= 1'b1;
        wr(twm_pkg::OFF_STOP_TASK, 32'h0000_0001);
        wait_evt(twm_pkg::OFF_STOPPED_EVENT);
        // Receive with a stretching slave
        wr(twm_pkg::OFF_STOPPED_EVENT, 32'h0000_0000);
        slow <= 1'b1;
        wr(twm_pkg::OFF_START_RECEIVE_TASK, 32'h0000_0001);
        wait_evt(twm_pkg::OFF_RECEIVE_STARTED_EVT);
        wait_bits(19);
        chk({23'b0, cap}, {23'b0, 7'h2A, 1'b1, 1'b0});
        wr(twm_pkg::OFF_STOP_TASK, 32'h0000_0001);
        wait_evt(twm_pkg::OFF_STOPPED_EVENT);
        rd(twm_pkg::OFF_RX_DATA, 32'h0000_00A5);
        tally_and_finish();
    end
endmodule
